/* File: dpwm_defs.vh */
`ifndef DPWM_DEFS_VH
`define DPWM_DEFS_VH

// register indices; byte address is four times the index
`define DPWM_IDX_DUTY0    6'h0F
`define DPWM_IDX_DUTY1    6'h10
`define DPWM_IDX_DUTY2    6'h11
`define DPWM_IDX_DUTY3    6'h12
`define DPWM_IDX_CTRL_A   6'h13
`define DPWM_IDX_RELOAD_A 6'h14
`define DPWM_IDX_DUTY4    6'h15
`define DPWM_IDX_DUTY5    6'h16
`define DPWM_IDX_CTRL_B   6'h17
`define DPWM_IDX_RELOAD_B 6'h18
`define DPWM_IDX_STATUS   6'h19

// reset values
`define DPWM_RST_DUTY     8'h00
`define DPWM_RST_CTRL     8'h00
`define DPWM_RST_RELOAD   8'hFF
`define DPWM_RST_COUNT    8'h00

// field positions in the control registers
`define DPWM_CTRL_A_OE_HI 7
`define DPWM_CTRL_A_OE_LO 4
`define DPWM_CTRL_A_OP_HI 3
`define DPWM_CTRL_A_OP_LO 0
`define DPWM_CTRL_B_OE_HI 5
`define DPWM_CTRL_B_OE_LO 4
`define DPWM_CTRL_B_OP_HI 1
`define DPWM_CTRL_B_OP_LO 0
// writable bits of control register B; bits 7:6 and 3:2 read 0
`define DPWM_CTRL_B_MASK  8'h33

// counter value at which the next edge overflows
`define DPWM_COUNT_TOP    8'hFF

// bus answers
`define DPWM_RESP_OKAY    2'h0
`define DPWM_RESP_SLVERR  2'h2

`endif

/* File: dpwm_top.v */
// Contract
// - 8-bit counter advances every clock edge
// - two independent blocks A and B
// - overflow reloads counter with reload value
// - outputs 0-3 period 256 minus reload A
// - outputs 4-5 period 256 minus reload B
// - overflow drives outputs to active level
// - compare match returns output to inactive
// - hidden shadow compare copied at overflow
// - width duty-reload+1, none if duty<reload
// - duty resolution one step in 256-reload
// - enable bit selects PWM or general I/O
// - enabled pin driven push-pull by PWM
// - control A: enables 7:4, polarity 3:0
// - control B: enables 5:4, polarity 1:0
// - control B bits 7:6,3:2 read zero
// - polarity change inverts output at once
// - reload A write restarts counter A
// - reload B write restarts counter B
`timescale 1ns/1ps
`include "dpwm_defs.vh"

module dpwm_top #(
  parameter ADDR_W = 8,                 // byte address width
  parameter CNT_W  = 8                  // counter and duty width
) (
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // axi4-lite write response
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // axi4-lite read data
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // general i/o levels from the port logic, same clock
  input  wire [5:0]        gpio_out,
  input  wire [5:0]        gpio_oe,
  // pins
  output wire [5:0]        modulated_output,
  output wire [5:0]        modulated_output_oe
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  reg  [CNT_W-1:0] duty_value_reg [0:5];  // software duty per output
  reg  [7:0]       group_a_control_reg;   // enables and polarities A
  reg  [7:0]       group_b_control_reg;   // enables and polarities B
  reg  [CNT_W-1:0] group_a_reload_reg;    // reload value A
  reg  [CNT_W-1:0] group_b_reload_reg;    // reload value B
  reg  [CNT_W-1:0] count_a_reg;           // block A counter
  reg  [CNT_W-1:0] count_b_reg;           // block B counter
  reg  [CNT_W-1:0] count_a_next;
  reg  [CNT_W-1:0] count_b_next;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  // a write needs both halves; each half is parked in its own holding
  // register so the master may offer them in either order. the commit
  // strobe wr_fire lasts one cycle and the answer follows on the next
  // edge. bvalid also blocks both readies, so a second write cannot be
  // taken before the first answer has been accepted.

  reg              aw_held_reg;           // address captured
  reg  [ADDR_W-1:0] aw_addr_reg;           // captured write address
  reg              w_held_reg;            // data captured
  reg  [31:0]      w_data_reg;            // captured write data
  reg  [3:0]       w_strb_reg;            // captured byte enables
  reg              bvalid_reg;            // response pending
  reg  [1:0]       bresp_reg;             // response code

  // hold each channel until the response has been taken
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  wire       wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire [5:0] wr_idx  = aw_addr_reg[7:2];
  // only lane 0 carries register data; other lanes are ignored
  wire       wr_lane = w_strb_reg[0];
  wire       wr_hit  = (aw_addr_reg[1:0] == 2'h0) &&
                       (ADDR_W <= 8 || aw_addr_reg[ADDR_W-1:0] < 8'h80) &&
                       ((wr_idx >= `DPWM_IDX_DUTY0 &&
                         wr_idx <= `DPWM_IDX_RELOAD_B) ||
                        wr_idx == `DPWM_IDX_STATUS);
  wire [7:0] wr_byte = w_data_reg[7:0];

  // per-register write strobes
  wire wr_ctrl_a   = wr_fire & wr_hit & wr_lane &
                     (wr_idx == `DPWM_IDX_CTRL_A);
  wire wr_ctrl_b   = wr_fire & wr_hit & wr_lane &
                     (wr_idx == `DPWM_IDX_CTRL_B);
  wire wr_reload_a = wr_fire & wr_hit & wr_lane &
                     (wr_idx == `DPWM_IDX_RELOAD_A);
  wire wr_reload_b = wr_fire & wr_hit & wr_lane &
                     (wr_idx == `DPWM_IDX_RELOAD_B);

  // write handshake and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `DPWM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // both halves present: commit and answer
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `DPWM_RESP_OKAY : `DPWM_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  // the registers are a byte wide, so only lane 0 and data bits 7:0
  // count; the upper lanes of the bus word are dropped on purpose.
  // control b is masked on the way in and again on the way out, so
  // its reserved bits can never hold a one.
  // control and reload storage; status index is read only
  always @(posedge aclk) begin
    if (!aresetn) begin
      group_a_control_reg <= `DPWM_RST_CTRL;
      group_b_control_reg <= `DPWM_RST_CTRL;
      group_a_reload_reg  <= `DPWM_RST_RELOAD;
      group_b_reload_reg  <= `DPWM_RST_RELOAD;
    end else begin
      if (wr_ctrl_a)
        group_a_control_reg <= wr_byte;
      if (wr_ctrl_b)
        group_b_control_reg <= wr_byte & `DPWM_CTRL_B_MASK;
      if (wr_reload_a)
        group_a_reload_reg <= wr_byte;
      if (wr_reload_b)
        group_b_reload_reg <= wr_byte;
    end
  end

  // enable and polarity vectors gathered per output
  // control a packs four enables over four polarities; control b
  // uses only bits 5:4 and 1:0 for outputs 5 and 4
  wire [5:0] enable_bits = {
    group_b_control_reg[`DPWM_CTRL_B_OE_HI:`DPWM_CTRL_B_OE_LO],
    group_a_control_reg[`DPWM_CTRL_A_OE_HI:`DPWM_CTRL_A_OE_LO]
  };
  wire [5:0] polarity_bits = {
    group_b_control_reg[`DPWM_CTRL_B_OP_HI:`DPWM_CTRL_B_OP_LO],
    group_a_control_reg[`DPWM_CTRL_A_OP_HI:`DPWM_CTRL_A_OP_LO]
  };

  ////////////////////////////////////////////////////////////////////////
  // counters

  // each block owns one free-running up-counter. at the top value the
  // next edge is the overflow: the counter takes the reload value, the
  // shadow compare values are refreshed and the phase is set again.
  // a period is therefore 256 minus the reload value clock cycles.
  // the counters leave reset at zero, so the first overflow only comes
  // after a full sweep; software normally restarts each block with a
  // reload write once the duties are in place.
  // overflow is the edge on which the counter would pass the top
  wire ovf_a = (count_a_reg == `DPWM_COUNT_TOP);
  wire ovf_b = (count_b_reg == `DPWM_COUNT_TOP);

  // next counts: a reload write beats the free run
  always @* begin
    count_a_next = count_a_reg + 8'h01;
    if (wr_reload_a)
      count_a_next = wr_byte;
    else if (ovf_a)
      count_a_next = group_a_reload_reg;
    count_b_next = count_b_reg + 8'h01;
    if (wr_reload_b)
      count_b_next = wr_byte;
    else if (ovf_b)
      count_b_next = group_b_reload_reg;
  end

  // two independent counters, one per block
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_a_reg <= `DPWM_RST_COUNT;
      count_b_reg <= `DPWM_RST_COUNT;
    end else begin
      count_a_reg <= count_a_next;
      count_b_reg <= count_b_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-output duty, shadow compare and pin

  // each output keeps a phase bit and a registered pin. the phase is
  // raised at overflow and dropped at compare match; the pin is the
  // phase turned by the polarity bit, or the general i/o level while
  // the output is disabled. registering the pin costs one cycle of
  // lag against the counter but keeps the pads free of decode
  // glitches, which matters for the external filters.
  wire [5:0] active_bits;                 // 1 while in the active phase

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_out
      // outputs 0-3 follow block A, 4-5 block B
      wire [CNT_W-1:0] count_i  = (i < 4) ? count_a_reg : count_b_reg;
      wire [CNT_W-1:0] reload_i = (i < 4) ? group_a_reload_reg
                                          : group_b_reload_reg;
      wire             ovf_i    = (i < 4) ? ovf_a : ovf_b;
      wire             rwr_i    = (i < 4) ? wr_reload_a : wr_reload_b;
      // register index as a full integer, cut to the 6-bit decode width
      localparam integer IDX_I = (i < 4) ? (`DPWM_IDX_DUTY0 + i)
                                         : (`DPWM_IDX_DUTY4 + i - 4);
      wire [5:0]       idx_i    = IDX_I[5:0];
      reg  [CNT_W-1:0] shadow_reg;        // hidden compare value
      reg              active_reg;        // phase before polarity
      reg              pin_reg;           // registered pin level
      reg              pin_oe_reg;        // registered drive enable

      // duty storage
      // duty writes land at once but act only at the next overflow
      always @(posedge aclk) begin
        if (!aresetn)
          duty_value_reg[i] <= `DPWM_RST_DUTY;
        else if (wr_fire && wr_hit && wr_lane && wr_idx == idx_i)
          duty_value_reg[i] <= wr_byte;
      end

      // shadow copy at overflow only, so a mid-period write
      // cannot produce a runt pulse
      always @(posedge aclk) begin
        if (!aresetn)
          shadow_reg <= `DPWM_RST_DUTY;
        else if (ovf_i)
          shadow_reg <= duty_value_reg[i];
      end

      // priority: reload write, then overflow, then compare. a duty of
      // ff therefore keeps the phase high for the whole period, and a
      // duty equal to the reload gives a one-cycle pulse.
      // phase: set at overflow, cleared at compare match
      always @(posedge aclk) begin
        if (!aresetn)
          active_reg <= 1'b0;
        else if (rwr_i)
          active_reg <= 1'b1;
        else if (ovf_i)
          // no pulse at all when duty sits below the reload
          active_reg <= (duty_value_reg[i] >= reload_i);
        else if (count_i == shadow_reg)
          active_reg <= 1'b0;
      end

      // with the enable bit clear the pad follows the port logic, so
      // switching an output off hands it back without a glitch cycle
      // pin mux; polarity applies on the next edge, not at overflow
      always @(posedge aclk) begin
        if (!aresetn) begin
          pin_reg    <= 1'b0;
          pin_oe_reg <= 1'b0;
        end else if (enable_bits[i]) begin
          pin_reg    <= active_reg ^ polarity_bits[i];
          pin_oe_reg <= 1'b1;
        end else begin
          pin_reg    <= gpio_out[i];
          pin_oe_reg <= gpio_oe[i];
        end
      end

      assign active_bits[i]         = active_reg;
      assign modulated_output[i]    = pin_reg;
      assign modulated_output_oe[i] = pin_oe_reg;
    end
  endgenerate

  // periods: block a sets the rate of outputs 0-3 and block b that of
  // outputs 4-5; the two never share a counter, so writing one reload
  // register leaves the other block's phases untouched.

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  // reads decode the address combinationally and register the answer,
  // so rdata and rresp are flop outputs that stand until rready.
  // arready falls while an answer waits: one read at a time only.
  // unmapped or misaligned addresses answer with an error and zero.

  reg         rvalid_reg;                 // read data pending
  reg  [31:0] rdata_reg;                  // read data
  reg  [1:0]  rresp_reg;                  // read answer
  reg  [31:0] rd_word;                    // decoded read value
  reg         rd_hit;                     // address is mapped
  wire [5:0]  rd_idx = s_axi_araddr[7:2];

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // read decode; narrow registers sit in the low byte
  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = (s_axi_araddr[1:0] == 2'h0) &&
              (ADDR_W <= 8 || s_axi_araddr[ADDR_W-1:0] < 8'h80);
    case (rd_idx)
      `DPWM_IDX_DUTY0:    rd_word[7:0] = duty_value_reg[0];
      `DPWM_IDX_DUTY1:    rd_word[7:0] = duty_value_reg[1];
      `DPWM_IDX_DUTY2:    rd_word[7:0] = duty_value_reg[2];
      `DPWM_IDX_DUTY3:    rd_word[7:0] = duty_value_reg[3];
      `DPWM_IDX_CTRL_A:   rd_word[7:0] = group_a_control_reg;
      `DPWM_IDX_RELOAD_A: rd_word[7:0] = group_a_reload_reg;
      `DPWM_IDX_DUTY4:    rd_word[7:0] = duty_value_reg[4];
      `DPWM_IDX_DUTY5:    rd_word[7:0] = duty_value_reg[5];
      `DPWM_IDX_CTRL_B:   rd_word[7:0] = group_b_control_reg &
                                         `DPWM_CTRL_B_MASK;
      `DPWM_IDX_RELOAD_B: rd_word[7:0] = group_b_reload_reg;
      // the status word is an addition of this block: it exposes the
      // live counts and phases so software can align duty updates
      // live counters and phases, for software and debug
      `DPWM_IDX_STATUS:   rd_word = {10'h000, active_bits,
                                     count_b_reg, count_a_reg};
      default:            rd_hit = 1'b0;
    endcase
    if (!rd_hit)
      rd_word = 32'h00000000;
  end

  // read handshake, one answer cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `DPWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `DPWM_RESP_OKAY : `DPWM_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

/* File: dpwm_checker.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// bus-side checks, pins seen at the top ports only
module dpwm_checker (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // write channels
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // read channels
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken on one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // halves are parked on the take edge, committed on the next
  property p_wr_ans; s_wr_take |-> ##2 s_axi_bvalid; endproperty
  property p_rd_ans; s_rd_take |=> s_axi_rvalid; endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  // only 8-bit registers and the status word exist
  property p_r_top; s_axi_rvalid |-> s_axi_rdata[31:22] == 10'h000;
  endproperty
  property p_r_err; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 0;
  endproperty
  a_wr_ans:  assert property (p_wr_ans)  else $error("no write answer");
  a_rd_ans:  assert property (p_rd_ans)  else $error("no read answer");
  a_b_hold:  assert property (p_b_hold)  else $error("bresp dropped");
  a_r_hold:  assert property (p_r_hold)  else $error("rdata dropped");
  a_b_block: assert property (p_b_block) else $error("write not refused");
  a_r_block: assert property (p_r_block) else $error("read not refused");
  a_b_done:  assert property (p_b_done)  else $error("bvalid stuck");
  a_r_done:  assert property (p_r_done)  else $error("rvalid stuck");
  a_r_top:   assert property (p_r_top)   else $error("bits set");
  a_r_err:   assert property (p_r_err)   else $error("error read data");
endmodule
bind dpwm_top dpwm_checker dpwm_checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* File: dpwm_top_bench.sv */
`timescale 1ns/1ps
`include "dpwm_defs.vh"
////////////////////////////////////////
module dpwm_top_bench;
  reg         aclk = 0, aresetn = 0;
  reg  [7:0]  awaddr = 0, araddr = 0;
  reg  [31:0] wdata = 0;
  reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg  [5:0]  gpio_out = 0, gpio_oe = 0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [5:0]  pwm, pwm_oe;
  int         err_count = 0, n_compared = 0;
  reg  [33:0] expq[$];                   // expected {rresp, rdata}
  reg  [1:0]  bq[$];                     // expected bresp
  reg  [15:0] lfsr = 16'h0002;           // random source
  reg  [7:0]  hi [0:5];                  // high cycles seen per pin
  reg  [7:0]  exph [0:5] = '{8'h0C, 8'h06, 8'h30, 8'h30, 8'h18, 8'h20};
  always #12.5 aclk = ~aclk;
  dpwm_top dpwm_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .modulated_output(pwm), .modulated_output_oe(pwm_oe));
  ////////////////////////////////////////
  function [7:0] ad(input [5:0] i); ad = {i, 2'b00}; endfunction
  function [15:0] lfsr_next(input [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input string nm, input [33:0] seen, input [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // both halves offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] d);
    bq.push_back(`DPWM_RESP_OKAY);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (awvalid || wvalid);
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
  endtask
  // the monitor below pairs the answer with the queued note
  task rd(input [7:0] a, input [33:0] exp);
    expq.push_back(exp);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    // rready stays up between reads, so it is never set twice at once
    do @(posedge aclk); while (!rvalid);
  endtask
  always @(posedge aclk) if (rvalid && rready)
    check("read", {rresp, rdata}, expq.pop_front());
  always @(posedge aclk) if (bvalid && bready)
    check("bresp", bresp, bq.pop_front());
  // high time summed over whole periods is phase independent
  task measure(input int n);
    int k;
    for (k = 0; k < 6; k++) hi[k] = 0;
    repeat (n) begin
      @(posedge aclk);
      for (k = 0; k < 6; k++) hi[k] += pwm[k];
    end
  endtask
  ////////////////////////////////////////
  initial begin
    int i;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (i = 15; i <= 24; i++)
      rd(ad(i), (i == 20 || i == 24) ? 34'hFF : 34'h0);
    rd(8'h68, {2'h2, 32'h0});            // unmapped place
    rd(8'h3D, {2'h2, 32'h0});            // misaligned
    wr(ad(`DPWM_IDX_CTRL_B), 32'hFF);
    rd(ad(`DPWM_IDX_CTRL_B), 34'h33);
    $display("register test done");
    // A period 8, B period 6; pin 2 and pin 5 inverted
    wr(ad(`DPWM_IDX_DUTY0), 32'hF9);
    wr(ad(`DPWM_IDX_DUTY1), 32'hF8);
    wr(ad(`DPWM_IDX_DUTY2), 32'hF7);
    wr(ad(`DPWM_IDX_DUTY3), 32'hFF);
    wr(ad(`DPWM_IDX_DUTY4), 32'hFC);
    wr(ad(`DPWM_IDX_DUTY5), 32'hFB);
    wr(ad(`DPWM_IDX_CTRL_A), 32'hF4);
    wr(ad(`DPWM_IDX_CTRL_B), 32'h32);
    wr(ad(`DPWM_IDX_RELOAD_A), 32'hF8);
    wr(ad(`DPWM_IDX_RELOAD_B), 32'hFA);
    repeat (20) @(posedge aclk);
    measure(48);
    for (i = 0; i < 6; i++)
      check("high time", hi[i], exph[i]);
    check("drive", pwm_oe, 6'h3F);
    $display("waveform test done");
    wr(ad(`DPWM_IDX_CTRL_A), 32'hF8);    // swap polarity of pins 2, 3
    repeat (2) @(posedge aclk);
    check("polarity", pwm[3:2], 2'b00);
    $display("polarity test done");
    wr(ad(`DPWM_IDX_CTRL_A), 32'h00);
    wr(ad(`DPWM_IDX_CTRL_B), 32'h00);
    repeat (4) begin
      // four steps a value, so enables as well as levels get ones
      repeat (4) lfsr = lfsr_next(lfsr);
      gpio_out <= lfsr[5:0];
      gpio_oe <= lfsr[11:6];
      repeat (3) @(posedge aclk);
      check("gpio", {pwm_oe, pwm}, {gpio_oe, gpio_out});
    end
    $display("general i/o test done");
    finish_test;
  end
  // watchdog well beyond the few hundred cycles needed
  initial begin
    #(25 * 5000);
    err_count++;
    finish_test;
  end
endmodule
